// ==== rif_frame_builder.sv ====
// Builder of host API frames for packets and samples from the radio
`timescale 1ns/1ps
// Notes on behaviour
// - Explicit frame when output option bit1 set
// - Explicit frame type byte is 0x91
// - Delimiter, then 16-bit length of inner bytes
// - 64-bit address at 4, network address 12
// - Source endpoint 14, destination endpoint 15
// - Cluster at 16, profile at 18
// - Options byte at 20, vendor endpoints only
// - Acked sets 0x01, broadcast sets 0x02
// - All-PAN 0x04, secure 0x10, encrypted 0x20
// - Bits 7:6 carry mesh delivery method
// - Option flags are ORed together
// - Payload follows options from offset 21
// - Checksum is 0xFF minus byte sum
// - Sample frame when output options zero
// - Sample frames only in framed API mode
// - Sample frame type byte is 0x92
// - Sample frame: addresses, acked/broadcast options
// - Sample set count at offset 15
// - Bit1 clear gives standard receive frame
module rif_frame_builder #(
    parameter int FIFO_DEPTH = rif_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic [7:0] api_output_options,
    input wire logic api_framed_mode,
    input wire logic pkt_valid,
    output logic pkt_ready,
    input wire logic pkt_is_sample,
    input wire logic [15:0] pkt_payload_len,
    input wire logic [63:0] src_addr64,
    input wire logic [15:0] src_net16,
    input wire logic [7:0] src_endpoint,
    input wire logic [7:0] dst_endpoint,
    input wire logic [15:0] cluster_id,
    input wire logic [15:0] profile_id,
    input wire logic rx_acked,
    input wire logic rx_broadcast,
    input wire logic rx_all_pans,
    input wire logic rx_secure,
    input wire logic rx_encrypted,
    input wire logic [1:0] rx_method,
    input wire logic [7:0] sample_sets,
    input wire logic pl_valid,
    output logic pl_ready,
    input wire logic [7:0] pl_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic busy
);
    import rif_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    rif_state_type state_q;
    rif_state_type state_d;
    logic [7:0] hdr_q [HDR_MAX];
    logic [7:0] hdr_d [HDR_MAX];
    logic [4:0] hdr_n_q;
    logic [4:0] hdr_n_d;
    logic [4:0] hidx_q;
    logic [15:0] len_q;
    logic [15:0] cnt_q;
    logic [7:0] sum_q;
    logic out_valid_q;
    logic [7:0] out_data_q;
    logic [7:0] byte_d;
    logic [7:0] opts_all;
    logic vendor_ep;
    logic want_explicit;
    logic want_standard;
    logic want_sample;
    logic emit;
    logic capture;
    logic slot_free;
    logic emitting;
    logic adv;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;

    // ****************************************************************
    // Payload buffer
    // ****************************************************************
    // The buffer lets the radio side run ahead while the host stalls;
    // once it is full, pl_ready drops and the radio side must wait.
    rif_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_payload_fifo (
        .clk(clk),
        .nrst(nrst),
        .en(en),
        .in_valid(pl_valid),
        .in_ready(pl_ready),
        .in_data(pl_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ****************************************************************
    // Frame selection
    // ****************************************************************
    assign want_explicit = !pkt_is_sample
        && api_output_options[AO_EXPLICIT_BIT];
    assign want_standard = !pkt_is_sample
        && !api_output_options[AO_EXPLICIT_BIT];
    // Samples go out only with zero output options and framed mode
    assign want_sample = pkt_is_sample
        && (api_output_options == 8'h00)
        && api_framed_mode;
    assign emit = want_explicit || want_standard || want_sample;

    assign pkt_ready = en && (state_q == ST_IDLE);
    assign capture = pkt_valid && pkt_ready;
    assign busy = (state_q != ST_IDLE);

    // ****************************************************************
    // Receive options byte
    // ****************************************************************
    always_comb begin
        opts_all = 8'h00;
        if (rx_acked) begin
            opts_all = opts_all | OPT_ACKED;
        end
        if (rx_broadcast) begin
            opts_all = opts_all | OPT_BCAST;
        end
        if (rx_all_pans) begin
            opts_all = opts_all | OPT_ALL_PAN;
        end
        if (rx_secure) begin
            opts_all = opts_all | OPT_SECURE;
        end
        if (rx_encrypted) begin
            opts_all = opts_all | OPT_ENCRYPTED;
        end
        opts_all = opts_all
            | 8'({6'h00, rx_method} << OPT_METHOD_LSB);
    end

    assign vendor_ep = (src_endpoint >= EP_VENDOR_LO)
        && (src_endpoint <= EP_VENDOR_HI);

    // ****************************************************************
    // Header image
    // ****************************************************************
    // The whole header is laid out at capture time so the radio side
    // need not hold its fields steady while the frame drains.
    always_comb begin
        for (int i = 0; i < HDR_MAX; i++) begin
            hdr_d[i] = 8'h00;
        end
        for (int i = 0; i < 8; i++) begin
            hdr_d[IDX_ADDR64+i] = src_addr64[63-8*i -: 8];
        end
        hdr_d[IDX_NET16] = src_net16[15:8];
        hdr_d[IDX_NET16+1] = src_net16[7:0];
        if (want_explicit) begin
            hdr_d[IDX_TYPE] = CODE_EXPLICIT;
            hdr_d[IDX_SRC_EP] = src_endpoint;
            hdr_d[IDX_DST_EP] = dst_endpoint;
            hdr_d[IDX_CLUSTER] = cluster_id[15:8];
            hdr_d[IDX_CLUSTER+1] = cluster_id[7:0];
            hdr_d[IDX_PROFILE] = profile_id[15:8];
            hdr_d[IDX_PROFILE+1] = profile_id[7:0];
            // Flags are meaningful only for the vendor endpoint range
            hdr_d[IDX_EXP_OPTS] = vendor_ep ? opts_all : 8'h00;
            hdr_n_d = HDR_N_EXPLICIT;
        end else if (pkt_is_sample) begin
            hdr_d[IDX_TYPE] = CODE_IO_SAMPLE;
            hdr_d[IDX_IO_OPTS] = opts_all & OPT_IO_MASK;
            hdr_d[IDX_IO_NUM] = sample_sets;
            hdr_n_d = HDR_N_IO;
        end else begin
            hdr_d[IDX_TYPE] = CODE_STANDARD;
            hdr_d[IDX_STD_OPTS] = opts_all;
            hdr_n_d = HDR_N_STANDARD;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < HDR_MAX; i++) begin
                hdr_q[i] <= 8'h00;
            end
            hdr_n_q <= HDR_N_STANDARD;
            len_q <= 16'h0000;
        end else if (capture) begin
            for (int i = 0; i < HDR_MAX; i++) begin
                hdr_q[i] <= hdr_d[i];
            end
            hdr_n_q <= hdr_n_d;
            len_q <= 16'(hdr_n_d) + pkt_payload_len;
        end
    end

    // ****************************************************************
    // Output byte slot
    // ****************************************************************
    // A single output register: a new byte loads when the slot is empty
    // or the host takes the present one in the same cycle.
    assign slot_free = en && (!out_valid_q || out_ready);
    assign emitting = (state_q != ST_IDLE) && (state_q != ST_DROP);
    assign adv = slot_free && emitting
        && ((state_q != ST_DATA) || fifo_valid);
    assign fifo_pop = (adv && (state_q == ST_DATA))
        || (en && (state_q == ST_DROP) && fifo_valid);

    always_comb begin
        case (state_q)
            ST_DELIM: byte_d = START_DELIM;
            ST_LEN_HI: byte_d = len_q[15:8];
            ST_LEN_LO: byte_d = len_q[7:0];
            ST_HDR: byte_d = hdr_q[hidx_q];
            ST_DATA: byte_d = fifo_data;
            ST_CSUM: byte_d = CSUM_BASE - sum_q;
            default: byte_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid_q <= 1'b0;
            out_data_q <= 8'h00;
        end else if (en) begin
            if (adv) begin
                out_valid_q <= 1'b1;
                out_data_q <= byte_d;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
        end
    end

    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    // ****************************************************************
    // Checksum
    // ****************************************************************
    // Sums header from the type byte on, then payload; wraps at 8 bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sum_q <= 8'h00;
        end else if (capture) begin
            sum_q <= 8'h00;
        end else if (adv && ((state_q == ST_HDR)
                || (state_q == ST_DATA))) begin
            sum_q <= sum_q + byte_d;
        end
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hidx_q <= 5'h00;
        end else if (capture) begin
            hidx_q <= 5'h00;
        end else if (adv && (state_q == ST_HDR)) begin
            hidx_q <= hidx_q + 5'h01;
        end
    end

    // Remaining payload bytes, shared by sending and discarding
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 16'h0000;
        end else if (capture) begin
            cnt_q <= pkt_payload_len;
        end else if (fifo_pop) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (capture && emit) begin
                    state_d = ST_DELIM;
                end else if (capture && (pkt_payload_len != 16'h0000)) begin
                    // Payload of a suppressed frame is still drained
                    state_d = ST_DROP;
                end
            end
            ST_DELIM: begin
                if (adv) begin
                    state_d = ST_LEN_HI;
                end
            end
            ST_LEN_HI: begin
                if (adv) begin
                    state_d = ST_LEN_LO;
                end
            end
            ST_LEN_LO: begin
                if (adv) begin
                    state_d = ST_HDR;
                end
            end
            ST_HDR: begin
                if (adv && (hidx_q == hdr_n_q - 5'h01)) begin
                    state_d = (cnt_q != 16'h0000) ? ST_DATA : ST_CSUM;
                end
            end
            ST_DATA: begin
                if (adv && (cnt_q == 16'h0001)) begin
                    state_d = ST_CSUM;
                end
            end
            ST_CSUM: begin
                if (adv) begin
                    state_d = ST_IDLE;
                end
            end
            ST_DROP: begin
                if (fifo_pop && (cnt_q == 16'h0001)) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else if (en) begin
            state_q <= state_d;
        end
    end

endmodule // rif_frame_builder

// ==== rif_pkg.sv ====
// Constants shared by the receive indicator frame builder
package rif_pkg;

    // ****************************************************************
    // Frame framing
    // ****************************************************************
    localparam logic [7:0] START_DELIM = 8'h7e;
    localparam logic [7:0] CODE_STANDARD = 8'h90;
    localparam logic [7:0] CODE_EXPLICIT = 8'h91;
    localparam logic [7:0] CODE_IO_SAMPLE = 8'h92;
    localparam logic [7:0] CSUM_BASE = 8'hff;

    // Header bytes from the frame type up to the first payload byte
    localparam logic [4:0] HDR_N_STANDARD = 5'h0c;
    localparam logic [4:0] HDR_N_EXPLICIT = 5'h12;
    localparam logic [4:0] HDR_N_IO = 5'h0d;
    localparam int HDR_MAX = 18;

    // Header byte index, counted from the frame type byte at offset 3
    localparam int IDX_TYPE = 0;
    localparam int IDX_ADDR64 = 1;
    localparam int IDX_NET16 = 9;
    localparam int IDX_STD_OPTS = 11;
    localparam int IDX_IO_OPTS = 11;
    localparam int IDX_IO_NUM = 12;
    localparam int IDX_SRC_EP = 11;
    localparam int IDX_DST_EP = 12;
    localparam int IDX_CLUSTER = 13;
    localparam int IDX_PROFILE = 15;
    localparam int IDX_EXP_OPTS = 17;

    // ****************************************************************
    // Receive options
    // ****************************************************************
    localparam logic [7:0] OPT_ACKED = 8'h01;
    localparam logic [7:0] OPT_BCAST = 8'h02;
    localparam logic [7:0] OPT_ALL_PAN = 8'h04;
    localparam logic [7:0] OPT_SECURE = 8'h10;
    localparam logic [7:0] OPT_ENCRYPTED = 8'h20;
    localparam int OPT_METHOD_LSB = 6;
    localparam logic [7:0] OPT_IO_MASK = 8'h03;
    localparam logic [7:0] EP_VENDOR_LO = 8'hdc;
    localparam logic [7:0] EP_VENDOR_HI = 8'hee;

    // ****************************************************************
    // Settings and sizes
    // ****************************************************************
    localparam int AO_EXPLICIT_BIT = 1;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int BYTE_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DELIM = 3'h1,
        ST_LEN_HI = 3'h3,
        ST_LEN_LO = 3'h2,
        ST_HDR = 3'h6,
        ST_DATA = 3'h7,
        ST_CSUM = 3'h5,
        ST_DROP = 3'h4
    } rif_state_type;

endpackage

// ==== rif_fifo.sv ====
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module rif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = en && (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = en && (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap explicitly so any depth works, not only powers of two
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule // rif_fifo

// ==== rif_frame_builder_props.sv ====
// Checker of frame builder handshakes and leading frame bytes
`timescale 1ns/1ps
module rif_frame_builder_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic [7:0] api_output_options,
    input wire logic api_framed_mode,
    input wire logic pkt_valid,
    input wire logic pkt_ready,
    input wire logic pkt_is_sample,
    input wire logic [15:0] pkt_payload_len,
    input wire logic pl_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic busy
);
    logic take;
    logic [1:0] kind_q;
    logic [15:0] len_q;
    logic [15:0] idx_q;
    assign take = pkt_valid && pkt_ready;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kind_q <= 2'h0;
            len_q <= 16'h0;
        end else if (take) begin
            kind_q <= pkt_is_sample ? 2'h2 : {1'b0, api_output_options[1]};
            len_q <= pkt_payload_len + (pkt_is_sample ? 16'h000d :
                api_output_options[1] ? 16'h0012 : 16'h000c);
        end
    end
    // Position in the frame of the byte now offered to the host
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_q <= 16'h0;
        end else if (take) begin
            idx_q <= 16'h0;
        end else if (out_valid && out_ready) begin
            idx_q <= idx_q + 16'h1;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_delim_first: assert property (
        take && !pkt_is_sample && !out_valid |-> ##2 out_valid &&
        out_data == 8'h7e) else $error("no delimiter after capture");
    a_len_high: assert property (
        out_valid && idx_q == 16'h1 |-> out_data == len_q[15:8])
        else $error("length high byte wrong");
    a_len_low: assert property (
        out_valid && idx_q == 16'h2 |-> out_data == len_q[7:0])
        else $error("length low byte wrong");
    a_type_code: assert property (
        out_valid && idx_q == 16'h3 |-> out_data == (kind_q == 2'h1 ?
        8'h91 : kind_q == 2'h2 ? 8'h92 : 8'h90))
        else $error("frame type byte wrong");
    a_take_busy: assert property (
        take && (!pkt_is_sample || pkt_payload_len != 16'h0 ||
        (api_framed_mode && api_output_options == 8'h00)) |=> busy &&
        !pkt_ready) else $error("capture did not start");
    a_ready_gate: assert property (
        pkt_ready |-> en && !busy) else $error("descriptor taken when busy");
    a_pl_gate: assert property (
        !en |-> !pl_ready) else $error("payload taken while frozen");
    a_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output byte changed before taken");
    a_quiet_sample: assert property (
        take && pkt_is_sample && !out_valid && (!api_framed_mode ||
        api_output_options != 8'h00) |=> !out_valid [*4])
        else $error("suppressed sample frame produced output");
endmodule // rif_frame_builder_props

// ==== rif_host_model.sv ====
// Host side model that collects frames and checks delimiter and sum
`timescale 1ns/1ps
module rif_host_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready,
    input wire logic slow,
    input wire logic stall
);
    logic [7:0] cur_q[$];
    logic [7:0] last_q[$];
    logic [7:0] sum;
    logic csum_ok = 1'b0;
    int frames = 0;
    // Slow mode takes a byte on every other cycle at most
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_ready <= 1'b0;
            cur_q.delete();
        end else begin
            out_ready <= !stall && (!slow || !out_ready);
            if (out_valid && out_ready) begin
                cur_q.push_back(out_data);
                if (cur_q.size() > 3 &&
                    cur_q.size() == 4 + {cur_q[1], cur_q[2]}) begin
                    sum = 8'h00;
                    for (int i = 3; i < cur_q.size(); i++) sum += cur_q[i];
                    csum_ok = sum == 8'hff && cur_q[0] == 8'h7e;
                    last_q = cur_q;
                    cur_q.delete();
                    frames++;
                end
            end
        end
    end
endmodule // rif_host_model

// ==== rif_frame_builder_tb.sv ====
// Self-checking bench for the receive indicator frame builder
`timescale 1ns/1ps
module rif_frame_builder_tb;
    typedef struct packed {
        logic smp; logic [7:0] ao; logic fr; logic [7:0] sep;
        logic [4:0] flg; logic [1:0] mth; logic [7:0] sets; logic [3:0] plen;
    } rif_row_type;
    localparam logic [63:0] A64 = 64'h1122334455667788;
    localparam logic [15:0] NET = 16'ha5c3;
    localparam logic [15:0] CLU = 16'h0011;
    localparam logic [15:0] PRO = 16'hc105;
    localparam logic [7:0] DEP = 8'he8;
    logic clk = 1'b0, nrst = 1'b0, en = 1'b1, api_framed_mode = 1'b1;
    logic pkt_valid = 1'b0, pkt_is_sample = 1'b0, pl_valid = 1'b0;
    logic rx_acked = 1'b0, rx_broadcast = 1'b0, rx_all_pans = 1'b0;
    logic rx_secure = 1'b0, rx_encrypted = 1'b0, slow = 1'b0, stall = 1'b0;
    logic [1:0] rx_method = 2'h0;
    logic [7:0] api_output_options = 8'h00, src_endpoint = 8'h00;
    logic [7:0] sample_sets = 8'h00, pl_data = 8'h00, pbase = 8'h30;
    logic [15:0] pkt_payload_len = 16'h0000;
    logic pkt_ready, pl_ready, out_valid, out_ready, busy;
    logic [7:0] out_data;
    int err_count = 0;
    int checks = 0;
    rif_row_type rows [12] = '{
        '{1'b0, 8'h02, 1'b1, 8'hdc, 5'h1f, 2'h3, 8'h00, 4'h0},
        '{1'b0, 8'h02, 1'b1, 8'hee, 5'h01, 2'h1, 8'h00, 4'h6},
        '{1'b0, 8'hff, 1'b1, 8'he8, 5'h02, 2'h2, 8'h00, 4'h1},
        '{1'b0, 8'h03, 1'b1, 8'hdb, 5'h1f, 2'h3, 8'h00, 4'h2},
        '{1'b0, 8'h02, 1'b1, 8'hef, 5'h0c, 2'h1, 8'h00, 4'h1},
        '{1'b0, 8'h00, 1'b1, 8'h00, 5'h05, 2'h1, 8'h00, 4'h3},
        '{1'b0, 8'h01, 1'b1, 8'h00, 5'h18, 2'h0, 8'h00, 4'ha},
        '{1'b1, 8'h00, 1'b1, 8'h00, 5'h1f, 2'h3, 8'h01, 4'h4},
        '{1'b1, 8'h00, 1'b1, 8'h00, 5'h02, 2'h0, 8'h02, 4'h0},
        '{1'b0, 8'h02, 1'b0, 8'he0, 5'h0a, 2'h2, 8'h00, 4'h1},
        '{1'b1, 8'h00, 1'b0, 8'h00, 5'h01, 2'h0, 8'h01, 4'h3},
        '{1'b1, 8'h02, 1'b1, 8'h00, 5'h01, 2'h0, 8'h01, 4'h2}};
    rif_frame_builder u_dut (.clk(clk), .nrst(nrst), .en(en),
        .api_output_options(api_output_options),
        .api_framed_mode(api_framed_mode), .pkt_valid(pkt_valid),
        .pkt_ready(pkt_ready), .pkt_is_sample(pkt_is_sample),
        .pkt_payload_len(pkt_payload_len), .src_addr64(A64),
        .src_net16(NET), .src_endpoint(src_endpoint), .dst_endpoint(DEP),
        .cluster_id(CLU), .profile_id(PRO), .rx_acked(rx_acked),
        .rx_broadcast(rx_broadcast), .rx_all_pans(rx_all_pans),
        .rx_secure(rx_secure), .rx_encrypted(rx_encrypted),
        .rx_method(rx_method), .sample_sets(sample_sets),
        .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data),
        .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .busy(busy));
    rif_host_model u_host (.clk(clk), .nrst(nrst), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .slow(slow),
        .stall(stall));
    always #5 clk = ~clk;
    task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Valid stays up across bytes so it is never driven twice per edge
    task automatic push_n(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            pl_valid <= 1'b1;
            pl_data <= b + 8'(i);
            do @(posedge clk); while (pl_ready !== 1'b1);
        end
        pl_valid <= 1'b0;
    endtask
    // ****************************************************************
    // One frame: expected bytes, drive, compare
    // ****************************************************************
    task automatic run_row(input rif_row_type r, input int pre);
        logic [7:0] q[$];
        logic [7:0] got[$];
        logic [7:0] opt;
        logic [7:0] s;
        int f0;
        int k;
        int oi;
        opt = {r.mth, r.flg[4:3], 1'b0, r.flg[2:0]};
        q = {r.smp ? 8'h92 : r.ao[1] ? 8'h91 : 8'h90};
        for (int i = 7; i >= 0; i--) q.push_back(A64[i*8 +: 8]);
        q = {q, NET[15:8], NET[7:0]};
        if (r.smp) q = {q, opt & 8'h03, r.sets};
        else if (r.ao[1]) q = {q, r.sep, DEP, CLU[15:8], CLU[7:0], PRO[15:8],
            PRO[7:0], (r.sep >= 8'hdc && r.sep <= 8'hee) ? opt : 8'h00};
        else q.push_back(opt);
        for (int i = 0; i < r.plen; i++) q.push_back(pbase + 8'(i));
        s = 8'hff;
        foreach (q[i]) s -= q[i];
        k = q.size();
        q = {8'h7e, 8'(k >> 8), 8'(k), q, s};
        oi = (r.ao[1] && !r.smp) ? 20 : 14;
        f0 = u_host.frames;
        @(posedge clk);
        pkt_is_sample <= r.smp;
        api_output_options <= r.ao;
        api_framed_mode <= r.fr;
        src_endpoint <= r.sep;
        {rx_encrypted, rx_secure, rx_all_pans, rx_broadcast, rx_acked} <= r.flg;
        rx_method <= r.mth;
        sample_sets <= r.sets;
        pkt_payload_len <= 16'(r.plen);
        pkt_valid <= 1'b1;
        fork
            begin
                do @(posedge clk); while (pkt_ready !== 1'b1);
                pkt_valid <= 1'b0;
            end
            push_n(r.plen - pre, pbase + 8'(pre));
        join
        pbase = pbase + 8'(r.plen);
        if (r.smp && (r.ao != 8'h00 || !r.fr)) begin
            for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clk);
            compare(8'(u_host.frames - f0), 8'h00);
            compare({7'h0, pl_ready}, 8'h01);
            compare({7'h0, busy}, 8'h00);
        end else begin
            for (k = 0; k < 500 && u_host.frames == f0; k++) @(posedge clk);
            got = u_host.last_q;
            compare(8'(u_host.frames - f0), 8'h01);
            compare(8'(got.size()), 8'(q.size()));
            foreach (q[i])
                compare(got[i], q[i]);
            compare(got[3], q[3]);
            compare(got[oi], q[oi]);
            compare({7'h0, u_host.csum_ok}, 8'h01);
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) run_row(rows[i], 0);
        // Fill the buffer while the host stalls, then drain it slowly
        stall <= 1'b1;
        push_n(8, pbase);
        #1 compare({7'h0, pl_ready}, 8'h00);
        @(posedge clk);
        stall <= 1'b0;
        slow <= 1'b1;
        run_row(rows[6], 8);
        // Reset in the middle of a frame
        slow <= 1'b0;
        pkt_is_sample <= 1'b0;
        api_output_options <= 8'h00;
        pkt_payload_len <= 16'h0000;
        pkt_valid <= 1'b1;
        @(posedge clk);
        pkt_valid <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1 compare({5'h0, out_valid, busy, pkt_ready}, 8'h01);
        @(posedge clk);
        nrst <= 1'b1;
        run_row(rows[1], 0);
        en <= 1'b0;
        @(posedge clk);
        #1 compare({6'h0, pkt_ready, pl_ready}, 8'h00);
        @(posedge clk);
        en <= 1'b1;
        run_row(rows[0], 0);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule // rif_frame_builder_tb
bind rif_frame_builder rif_frame_builder_props u_props (.clk(clk),
    .nrst(nrst), .en(en), .api_output_options(api_output_options),
    .api_framed_mode(api_framed_mode), .pkt_valid(pkt_valid),
    .pkt_ready(pkt_ready), .pkt_is_sample(pkt_is_sample),
    .pkt_payload_len(pkt_payload_len), .pl_ready(pl_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .busy(busy));
